// ---- asi_pkg.sv ----
package asi_pkg;
    // Register offsets from the module base address
    localparam logic [2:0] OFS_RATE_HI   = 3'h0;
    localparam logic [2:0] OFS_RATE_LO   = 3'h1;
    localparam logic [2:0] OFS_CTRL1     = 3'h2;
    localparam logic [2:0] OFS_CTRL2     = 3'h3;
    localparam logic [2:0] OFS_STAT1     = 3'h4;
    localparam logic [2:0] OFS_STAT2     = 3'h5;
    localparam logic [2:0] OFS_DATA_HI   = 3'h6;
    localparam logic [2:0] OFS_DATA_LO   = 3'h7;
    // Sixteen receiver ticks per bit
    localparam logic [16:0] RT_STEP      = 17'h00010;
    localparam logic [3:0]  RT_LAST      = 4'hf;
    localparam logic [3:0]  RT_S1        = 4'h7;
    localparam logic [3:0]  RT_S3        = 4'h9;
    localparam logic [3:0]  RT_COL       = 4'h9;
    localparam logic [3:0]  IR_PW_WIDE   = 4'h3;
    localparam logic [3:0]  IR_PW_NARROW = 4'h1;
    localparam logic [3:0]  BITS_8       = 4'h8;
    localparam logic [3:0]  BITS_9       = 4'h9;
    localparam logic [3:0]  FRAME_EXTRA  = 4'h2;
    // Sticky flag positions
    localparam int FL_IDLE = 0;
    localparam int FL_OVR  = 1;
    localparam int FL_NOISE = 2;
    localparam int FL_FRM  = 3;
    localparam int FL_PAR  = 4;
    localparam int FL_EDGE = 5;
    localparam int FL_COL  = 6;
    localparam int FL_BRK  = 7;
    localparam int NFLAGS  = 8;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asi_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asi_rx_state_t;
endpackage

// ---- asi_top.sv ----
`timescale 1ns/1ns
// Overview of operation
// - Transmit pin rests high between characters in NRZ and infrared formats.
// - Transmit pin is released (enable low) whenever the transmitter is off.
// - Continuous high on the receive line means idle.
// - Disabled receiver ignores the receive pin; NRZ collision checking still reads it.
// - Behaviour is identical in every chip operating mode.
// - Run, wait and stop power states are supported.
// - Registers sit at base plus fixed per-register offsets.
// - Full duplex on two pins or half duplex on one wire.
// - Standard format sends NRZ mark/space levels.
// - Selectable infrared RZI format with programmable pulse width.
// - Bit rate comes from a 16-bit divisor.
// - Characters carry 8 or 9 data bits.
// - Transmitter and receiver enable independently.
// - Transmit and receive polarity each programmable.
// - Optional parity bit, even or odd, appended on transmit.
// - Standby receiver wakes on idle line or address-marked character.
// - Flags: tx empty, tx complete, rx full, idle, overrun, noise, framing, parity.
// - Active receive edge raises a flag for wakeup.
// - In NRZ format the transmitter compares sent and line bit, flags collision.
// - Receiver detects a break and flags it.
// - Stop bit found low gives a framing error.
// - Infrared off: bit rate is clock over full divisor.
// - Infrared on: bit rate is clock over twice divisor bits 15..1.
// - Rate generator stops when upper divisor bits are all zero.
// - Reserved locations ignore writes and read zero.
module asi_top (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [15:0] rate_divisor_in,
    input  wire logic        infrared_select_in,
    input  wire logic        ir_narrow_in,
    input  wire logic        nine_bit_in,
    input  wire logic        tx_en_in,
    input  wire logic        rx_en_in,
    input  wire logic        tx_inv_in,
    input  wire logic        rx_inv_in,
    input  wire logic        parity_en_in,
    input  wire logic        parity_odd_in,
    input  wire logic        single_wire_in,
    input  wire logic        wake_addr_in,
    input  wire logic        standby_set_in,
    input  wire logic        stop_in,
    input  wire logic        wait_in,
    input  wire logic        wait_halt_in,
    input  wire logic [8:0]  tx_data_in,
    input  wire logic        tx_write_in,
    input  wire logic        rx_read_in,
    input  wire logic [7:0]  flag_clear_in,
    input  wire logic        rxd_in,
    input  wire logic        txd_in,
    output logic             txd_out,
    output logic             txd_oe_out,
    output logic [8:0]       rx_data_out,
    output logic             tx_empty_out,
    output logic             tx_done_out,
    output logic             rx_full_out,
    output logic             standby_out,
    output logic [7:0]       flags_out
);
    ////////////////////////////////////////////////////////////////////////
    // No mode input: behaviour never depends on chip operating mode
    // Offsets live in asi_pkg; no bus, so no reserved decode here
    // Stop freezes the rate generator; wait does so if asked
    logic        run;
    logic        rate_off;
    logic [15:0] div;
    logic [16:0] acc_q, acc_d, sum;
    logic        tick_q, tick_d;
    logic [3:0]  nbits;
    logic [8:0]  dmask;
    logic        rx_line;

    assign run   = ~stop_in & ~(wait_in & wait_halt_in);
    assign nbits = nine_bit_in ? asi_pkg::BITS_9 : asi_pkg::BITS_8;
    assign dmask = nine_bit_in ? 9'h1ff : 9'h0ff;
    // Single-wire reads the transmit pin; polarity applied
    assign rx_line = (single_wire_in ? txd_in : rxd_in) ^ rx_inv_in;
    assign div = infrared_select_in ? {rate_divisor_in[15:1], 1'b0} : rate_divisor_in;
    assign rate_off = infrared_select_in ? ~|rate_divisor_in[15:5] : ~|rate_divisor_in[15:4];
    assign sum = acc_q + asi_pkg::RT_STEP;

    // Fractional accumulator: sixteen ticks per divisor clocks
    always_comb begin
        acc_d  = sum;
        tick_d = 1'b0;
        if (rate_off || !(tx_en_in || rx_en_in) || !run) begin
            acc_d = '0;
        end else if (sum >= {1'b0, div}) begin
            acc_d  = sum - {1'b0, div};
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            tick_q <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    asi_pkg::asi_tx_state_t tx_st_q, tx_st_d;
    logic [3:0] tx_rt_q, tx_rt_d, tx_cnt_q, tx_cnt_d, pw;
    logic [8:0] tx_buf_q, tx_buf_d, tx_sh_q, tx_sh_d;
    logic       tdre_q, tdre_d, tc_q, tc_d, txd_q, txd_d, oe_q, oe_d;
    logic       tx_bit, col_set;

    assign pw = ir_narrow_in ? asi_pkg::IR_PW_NARROW : asi_pkg::IR_PW_WIDE;

    // Bit on the line per state
    always_comb begin
        case (tx_st_q)
            asi_pkg::TX_START: tx_bit = 1'b0;
            asi_pkg::TX_DATA:  tx_bit = tx_sh_q[tx_cnt_q];
            asi_pkg::TX_PAR:   tx_bit = ^(tx_sh_q & dmask) ^ parity_odd_in;
            default:           tx_bit = 1'b1;
        endcase
    end

    always_comb begin
        tx_st_d  = tx_st_q;
        tx_rt_d  = tx_rt_q;
        tx_cnt_d = tx_cnt_q;
        tx_buf_d = tx_buf_q;
        tx_sh_d  = tx_sh_q;
        tdre_d   = tdre_q;
        col_set  = 1'b0;
        // Writes while the buffer is full are dropped
        if (tx_write_in && tdre_q) begin
            tx_buf_d = tx_data_in;
            tdre_d   = 1'b0;
        end
        // Transmitter runs on its own enable
        if (!tx_en_in) begin
            tx_st_d = asi_pkg::TX_IDLE;
        end else if (tick_q) begin
            case (tx_st_q)
                asi_pkg::TX_IDLE: begin
                    if (!tdre_q) begin
                        tx_sh_d = tx_buf_q;
                        tdre_d  = 1'b1;
                        tx_st_d = asi_pkg::TX_START;
                        tx_rt_d = '0;
                    end
                end
                default: begin
                    tx_rt_d = tx_rt_q + 4'h1;
                    // Collision: line differs from sent bit mid-bit
                    if (!infrared_select_in && tx_rt_q == asi_pkg::RT_COL && rx_line != tx_bit) begin
                        col_set = 1'b1;
                    end
                    if (tx_rt_q == asi_pkg::RT_LAST) begin
                        case (tx_st_q)
                            asi_pkg::TX_START: begin
                                tx_st_d  = asi_pkg::TX_DATA;
                                tx_cnt_d = '0;
                            end
                            asi_pkg::TX_DATA: begin
                                if (tx_cnt_q == nbits - 4'h1) begin
                                    tx_st_d = parity_en_in ? asi_pkg::TX_PAR : asi_pkg::TX_STOP;
                                end else begin
                                    tx_cnt_d = tx_cnt_q + 4'h1;
                                end
                            end
                            asi_pkg::TX_PAR: tx_st_d = asi_pkg::TX_STOP;
                            default:         tx_st_d = asi_pkg::TX_IDLE;
                        endcase
                    end
                end
            endcase
        end
        tc_d = (tx_st_d == asi_pkg::TX_IDLE) && tdre_d;
        // NRZ level, or low pulse of pw ticks per zero bit
        txd_d = (infrared_select_in ? (tx_bit | (tx_rt_q >= pw)) : tx_bit) ^ tx_inv_in;
        oe_d = tx_en_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_st_q  <= asi_pkg::TX_IDLE;
            tx_rt_q  <= '0;
            tx_cnt_q <= '0;
            tx_buf_q <= '0;
            tx_sh_q  <= '0;
            tdre_q   <= 1'b1;
            tc_q     <= 1'b1;
            txd_q    <= 1'b1;
            oe_q     <= 1'b0;
        end else begin
            tx_st_q  <= tx_st_d;
            tx_rt_q  <= tx_rt_d;
            tx_cnt_q <= tx_cnt_d;
            tx_buf_q <= tx_buf_d;
            tx_sh_q  <= tx_sh_d;
            tdre_q   <= tdre_d;
            tc_q     <= tc_d;
            txd_q    <= txd_d;
            oe_q     <= oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    asi_pkg::asi_rx_state_t rx_st_q, rx_st_d;
    logic [3:0] rx_rt_q, rx_rt_d, rx_cnt_q, rx_cnt_d, flen;
    logic [8:0] rx_sh_q, rx_sh_d, rx_dat_q, rx_dat_d;
    logic [2:0] smp_q, smp_d;
    logic [7:0] icnt_q, icnt_d;
    logic       lows_q, lows_d, perr_q, perr_d, rdrf_q, rdrf_d;
    logic       stby_q, stby_d, iarm_q, iarm_d, line_q;
    logic       maj, noisy, bitv, mark, deliver, frame_end;
    logic [7:0] fset, flag_q, flag_d;

    assign maj   = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
    assign noisy = !infrared_select_in && (smp_q != 3'h0) && (smp_q != 3'h7);
    // Infrared zero is any low pulse in the bit
    assign bitv  = infrared_select_in ? ~lows_q : maj;
    assign flen  = nbits + asi_pkg::FRAME_EXTRA + {3'h0, parity_en_in};
    assign mark  = nine_bit_in ? rx_sh_q[8] : rx_sh_q[7];
    // Address mark wakes a standby receiver
    assign deliver   = !stby_q || (wake_addr_in && mark);
    assign frame_end = rx_en_in && tick_q && rx_st_q == asi_pkg::RX_STOP && rx_rt_q == asi_pkg::RT_LAST;

    always_comb begin
        rx_st_d  = rx_st_q;
        rx_rt_d  = rx_rt_q;
        rx_cnt_d = rx_cnt_q;
        rx_sh_d  = rx_sh_q;
        rx_dat_d = rx_dat_q;
        smp_d    = smp_q;
        lows_d   = lows_q;
        perr_d   = perr_q;
        icnt_d   = icnt_q;
        iarm_d   = iarm_q;
        rdrf_d   = rdrf_q & ~rx_read_in;
        stby_d   = stby_q | standby_set_in;
        fset     = '0;
        fset[asi_pkg::FL_COL] = col_set;
        if (rx_en_in && line_q && !rx_line) begin
            fset[asi_pkg::FL_EDGE] = 1'b1;
        end
        // Disabled receiver holds idle and raises nothing
        if (!rx_en_in) begin
            rx_st_d = asi_pkg::RX_IDLE;
            icnt_d  = '0;
        end else if (tick_q) begin
            case (rx_st_q)
                asi_pkg::RX_IDLE: begin
                    if (!rx_line) begin
                        rx_st_d = asi_pkg::RX_START;
                        rx_rt_d = '0;
                        // A narrow start pulse may be this one sample
                        lows_d  = 1'b1;
                        icnt_d  = '0;
                    end else if (iarm_q) begin
                        // A frame's worth of high ticks is idle
                        if (icnt_q == {flen, 4'h0}) begin
                            iarm_d = 1'b0;
                            // Idle wakeup, no flag while asleep
                            if (stby_q) begin
                                stby_d = wake_addr_in;
                            end else begin
                                fset[asi_pkg::FL_IDLE] = 1'b1;
                            end
                        end else begin
                            icnt_d = icnt_q + 8'h01;
                        end
                    end
                end
                default: begin
                    rx_rt_d = rx_rt_q + 4'h1;
                    lows_d  = lows_q | ~rx_line;
                    if (rx_rt_q >= asi_pkg::RT_S1 && rx_rt_q <= asi_pkg::RT_S3) begin
                        smp_d[rx_rt_q[1:0] - 2'h3] = rx_line;
                    end
                    if (rx_rt_q == asi_pkg::RT_LAST) begin
                        // This sample already opens the next bit
                        lows_d = ~rx_line;
                        if (noisy && !stby_q) begin
                            fset[asi_pkg::FL_NOISE] = 1'b1;
                        end
                        case (rx_st_q)
                            asi_pkg::RX_START: begin
                                rx_st_d  = bitv ? asi_pkg::RX_IDLE : asi_pkg::RX_DATA;
                                rx_cnt_d = '0;
                            end
                            asi_pkg::RX_DATA: begin
                                rx_sh_d[rx_cnt_q] = bitv;
                                if (!nine_bit_in) begin
                                    rx_sh_d[8] = 1'b0;
                                end
                                perr_d = 1'b0;
                                if (rx_cnt_q == nbits - 4'h1) begin
                                    rx_st_d = parity_en_in ? asi_pkg::RX_PAR : asi_pkg::RX_STOP;
                                end else begin
                                    rx_cnt_d = rx_cnt_q + 4'h1;
                                end
                            end
                            asi_pkg::RX_PAR: begin
                                perr_d  = bitv ^ (^(rx_sh_q & dmask)) ^ parity_odd_in;
                                rx_st_d = asi_pkg::RX_STOP;
                            end
                            default: begin
                                rx_st_d = asi_pkg::RX_IDLE;
                                iarm_d  = 1'b1;
                                icnt_d  = '0;
                                if (deliver) begin
                                    stby_d = 1'b0;
                                    // Unread character is kept, new one lost
                                    if (rdrf_q && !rx_read_in) begin
                                        fset[asi_pkg::FL_OVR] = 1'b1;
                                    end else begin
                                        rdrf_d   = 1'b1;
                                        rx_dat_d = rx_sh_q;
                                    end
                                    fset[asi_pkg::FL_FRM] = ~bitv;
                                    fset[asi_pkg::FL_PAR] = parity_en_in & perr_q;
                                    // All-zero frame with low stop is a break
                                    fset[asi_pkg::FL_BRK] = ~bitv & ~|rx_sh_q;
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_st_q  <= asi_pkg::RX_IDLE;
            rx_rt_q  <= '0;
            rx_cnt_q <= '0;
            rx_sh_q  <= '0;
            rx_dat_q <= '0;
            smp_q    <= '0;
            lows_q   <= 1'b0;
            perr_q   <= 1'b0;
            icnt_q   <= '0;
            iarm_q   <= 1'b0;
            rdrf_q   <= 1'b0;
            stby_q   <= 1'b0;
            line_q   <= 1'b1;
        end else begin
            rx_st_q  <= rx_st_d;
            rx_rt_q  <= rx_rt_d;
            rx_cnt_q <= rx_cnt_d;
            rx_sh_q  <= rx_sh_d;
            rx_dat_q <= rx_dat_d;
            smp_q    <= smp_d;
            lows_q   <= lows_d;
            perr_q   <= perr_d;
            icnt_q   <= icnt_d;
            iarm_q   <= iarm_d;
            rdrf_q   <= rdrf_d;
            stby_q   <= stby_d;
            line_q   <= rx_line;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags; a set in the clearing cycle wins
    for (genvar i = 0; i < asi_pkg::NFLAGS; i++) begin : g_flag
        always_comb begin
            flag_d[i] = fset[i] | (flag_q[i] & ~flag_clear_in[i]);
        end
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                flag_q[i] <= 1'b0;
            end else begin
                flag_q[i] <= flag_d[i];
            end
        end
    end

    assign txd_out      = txd_q;
    assign txd_oe_out   = oe_q;
    assign rx_data_out  = rx_dat_q;
    assign tx_empty_out = tdre_q;
    assign tx_done_out  = tc_q;
    assign rx_full_out  = rdrf_q;
    assign standby_out  = stby_q;
    assign flags_out    = flag_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_stop_low;
        frame_end && deliver && !bitv;
    endsequence
    sequence s_lost_char;
        frame_end && deliver && rdrf_q && !rx_read_in;
    endsequence

    chk_idle_high: assert property ((tx_st_q == asi_pkg::TX_IDLE) |=> (txd_out == ~$past(tx_inv_in)))
        else $error("transmit line not idle high");
    chk_tx_release: assert property (!tx_en_in |=> !txd_oe_out)
        else $error("transmit pin driven while disabled");
    chk_rx_ignore: assert property (!rx_en_in |=> (rx_st_q == asi_pkg::RX_IDLE) && !flags_out[asi_pkg::FL_EDGE]
        || $past(flags_out[asi_pkg::FL_EDGE]))
        else $error("disabled receiver reacted");
    chk_rate_stop: assert property (rate_off |=> !tick_q)
        else $error("rate generator ran while stopped");
    chk_rate_freeze: assert property (!run |=> !tick_q)
        else $error("rate generator ran while frozen");
    chk_start_low: assert property ((tx_st_q == asi_pkg::TX_START && !infrared_select_in) |=>
        (txd_out == $past(tx_inv_in)))
        else $error("start bit not low");
    chk_frame_err: assert property (s_stop_low |=> flags_out[asi_pkg::FL_FRM])
        else $error("framing error missed");
    chk_overrun_set: assert property (s_lost_char |=> flags_out[asi_pkg::FL_OVR] && $stable(rx_data_out))
        else $error("overrun not flagged or data overwritten");
    chk_col_flag: assert property (col_set |=> flags_out[asi_pkg::FL_COL])
        else $error("collision not flagged");
    chk_tx_load: assert property ((tx_write_in && tdre_q) |=> !tx_empty_out ##[1:300] 1'b1)
        else $error("transmit buffer not taken");
endmodule // asi_top

// ---- asi_peer.sv ----
`timescale 1ns/1ns
module asi_peer #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk_in,
    input  wire logic line_in,
    input  wire logic inv_in,
    output logic      rxd_out
);
    logic lvl;
    // Pin inversion applied here so idle stays a mark on the line
    assign rxd_out = lvl ^ inv_in;
    initial lvl = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    // whole frame, then line back to mark
    task automatic send_frame(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            lvl <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk_in);
        end
        @(posedge clk_in);
        lvl <= 1'b1;
    endtask
    task automatic recv_frame(output logic [11:0] f, input int n);
        int w;
        f = '1;
        for (w = 0; w < 400 && (line_in ^ inv_in) !== 1'b0; w++) @(posedge clk_in);
        repeat (BIT_CLKS / 2) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            f[i] = line_in ^ inv_in;
            repeat (BIT_CLKS) @(posedge clk_in);
        end
    endtask
endmodule // asi_peer

// ---- asi_tb_top.sv ----
`timescale 1ns/1ns
`define ASI_CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module asi_tb_top;
    logic        clk_in, rst_n_in, infrared_select_in, ir_narrow_in, nine_bit_in, tx_en_in, rx_en_in;
    logic        tx_inv_in, rx_inv_in, parity_en_in, parity_odd_in, single_wire_in, wake_addr_in;
    logic        standby_set_in, stop_in, wait_in, wait_halt_in, tx_write_in, rx_read_in, rxd_in, txd_in;
    logic        txd_out, txd_oe_out, tx_empty_out, tx_done_out, rx_full_out, standby_out, bad_par, bad_stop;
    logic [15:0] rate_divisor_in;
    logic [8:0]  tx_data_in, rx_data_out, d;
    logic [7:0]  flag_clear_in, flags_out;
    logic [11:0] got;
    int          n, miscompares, check_count;
    integer      seed;
    // Released pin pulled up
    assign txd_in = txd_oe_out ? txd_out : 1'b1;
    asi_top asi_top_inst (.clk_in, .rst_n_in, .rate_divisor_in, .infrared_select_in, .ir_narrow_in, .nine_bit_in,
        .tx_en_in, .rx_en_in, .tx_inv_in, .rx_inv_in, .parity_en_in, .parity_odd_in, .single_wire_in,
        .wake_addr_in, .standby_set_in, .stop_in, .wait_in, .wait_halt_in, .tx_data_in, .tx_write_in,
        .rx_read_in, .flag_clear_in, .rxd_in, .txd_in, .txd_out, .txd_oe_out, .rx_data_out, .tx_empty_out,
        .tx_done_out, .rx_full_out, .standby_out, .flags_out);
    asi_peer asi_peer_inst (.clk_in(clk_in), .line_in(txd_in), .inv_in(tx_inv_in), .rxd_out(rxd_in));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] mk_frame(input logic [8:0] dv, input logic nine, pe, po, flip, stop);
        logic [11:0] r;
        int          k;
        r = '1;
        r[0] = 1'b0;
        for (int i = 0; i < 9; i++) if (i < 8 + nine) r[i + 1] = dv[i];
        k = 9 + nine;
        if (pe) r[k] = ^dv ^ po ^ flip;
        r[k + pe] = stop;
        return r;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_hi(input int sel);
        int w;
        for (w = 0; w < 400 && (sel ? tx_done_out : rx_full_out) !== 1'b1; w++) @(posedge clk_in);
        `ASI_CHECK("completion", 1'b1, sel ? tx_done_out : rx_full_out)
        if (w == 400) end_of_test();
    endtask
    task automatic pulse_read();
        rx_read_in <= 1'b1;
        @(posedge clk_in);
        rx_read_in <= 1'b0;
        @(posedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        seed = 32'h134f;
        {infrared_select_in, ir_narrow_in, nine_bit_in, tx_en_in, rx_en_in, tx_inv_in, rx_inv_in} = '0;
        {parity_en_in, parity_odd_in, single_wire_in, wake_addr_in, standby_set_in, stop_in} = '0;
        {wait_in, wait_halt_in, tx_write_in, rx_read_in, tx_data_in, flag_clear_in} = '0;
        {miscompares, check_count} = '0;
        rate_divisor_in = 16'h0010;
        rst_n_in = 1'b0;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        `ASI_CHECK("txd level", 1'b1, txd_out)
        `ASI_CHECK("txd enable", 1'b0, txd_oe_out)
        @(posedge clk_in);
        tx_en_in <= 1'b1;
        rx_en_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        `ASI_CHECK("txd idle", 1'b1, txd_oe_out && txd_out)
        for (int c = 0; c < 16; c++) begin
            d = (c == 1) ? 9'h1ff : (c < 4) ? 9'h000 : 9'($random(seed));
            if (!c[0]) d[8] = 1'b0;
            {nine_bit_in, parity_en_in, parity_odd_in} <= {c[0], c[1], c[2]};
            {tx_inv_in, rx_inv_in} <= {c[3], c[3]};
            {ir_narrow_in, wake_addr_in, wait_in} <= d[3:1];
            repeat (3) @(posedge clk_in);
            tx_data_in <= d;
            tx_write_in <= 1'b1;
            @(posedge clk_in);
            tx_write_in <= 1'b0;
            n = 10 + c[0] + c[1];
            asi_peer_inst.recv_frame(got, n);
            `ASI_CHECK("tx frame", mk_frame(d, c[0], c[1], c[2], 1'b0, 1'b1), got)
            wait_hi(1);
            `ASI_CHECK("collision flag", 1'b1, flags_out[asi_pkg::FL_COL])
            bad_par = c > 3 && c[1] && d[4];
            bad_stop = c == 2 || (c > 3 && d[5]);
            flag_clear_in <= 8'hff;
            @(posedge clk_in);
            flag_clear_in <= 8'h00;
            asi_peer_inst.send_frame(mk_frame(d, c[0], c[1], c[2], bad_par, !bad_stop), n);
            wait_hi(0);
            `ASI_CHECK("rx data", d, rx_data_out)
            `ASI_CHECK("parity flag", bad_par, flags_out[asi_pkg::FL_PAR])
            `ASI_CHECK("framing flag", bad_stop, flags_out[asi_pkg::FL_FRM])
            `ASI_CHECK("break flag", bad_stop && d == 9'h000, flags_out[asi_pkg::FL_BRK])
            `ASI_CHECK("noise flag", 1'b0, flags_out[asi_pkg::FL_NOISE])
            `ASI_CHECK("edge flag", 1'b1, flags_out[asi_pkg::FL_EDGE])
            pulse_read();
            `ASI_CHECK("rx cleared", 1'b0, rx_full_out)
        end
        {nine_bit_in, parity_en_in} <= 2'h0;
        flag_clear_in <= 8'hff;
        @(posedge clk_in);
        flag_clear_in <= 8'h00;
        // Second character lands before the first is read
        for (int c = 0; c < 2; c++) asi_peer_inst.send_frame(mk_frame(9'(8'h5a + c), 0, 0, 0, 0, 1), 10);
        repeat (24) @(posedge clk_in);
        `ASI_CHECK("overrun flag", 1'b1, flags_out[asi_pkg::FL_OVR])
        `ASI_CHECK("kept data", 9'h05a, rx_data_out)
        repeat (200) @(posedge clk_in);
        `ASI_CHECK("idle flag", 1'b1, flags_out[asi_pkg::FL_IDLE])
        pulse_read();
        // Address-mark wake: unmarked character dropped, marked one delivered
        standby_set_in <= 1'b1;
        wake_addr_in <= 1'b1;
        @(posedge clk_in);
        standby_set_in <= 1'b0;
        asi_peer_inst.send_frame(mk_frame(9'h012, 0, 0, 0, 0, 1), 10);
        repeat (24) @(posedge clk_in);
        `ASI_CHECK("standby drop", 1'b0, rx_full_out)
        `ASI_CHECK("standby held", 1'b1, standby_out)
        asi_peer_inst.send_frame(mk_frame(9'h092, 0, 0, 0, 0, 1), 10);
        wait_hi(0);
        `ASI_CHECK("wake data", 9'h092, rx_data_out)
        `ASI_CHECK("standby left", 1'b0, standby_out)
        pulse_read();
        // Infrared loopback over one wire with narrow pulses
        {infrared_select_in, single_wire_in, ir_narrow_in} <= 3'h7;
        rate_divisor_in <= 16'h0020;
        d = {1'b0, 8'($random(seed))};
        tx_data_in <= d;
        tx_write_in <= 1'b1;
        @(posedge clk_in);
        tx_write_in <= 1'b0;
        wait_hi(0);
        `ASI_CHECK("ir loopback", d, rx_data_out)
        {infrared_select_in, single_wire_in} <= 2'h0;
        rate_divisor_in <= 16'h0010;
        pulse_read();
        rx_en_in <= 1'b0;
        asi_peer_inst.send_frame(mk_frame(9'h000, 0, 0, 0, 0, 0), 10);
        repeat (8) @(posedge clk_in);
        `ASI_CHECK("rx ignored", 1'b0, rx_full_out)
        `ASI_CHECK("break ignored", 1'b0, flags_out[asi_pkg::FL_BRK])
        // Stop freezes the ticks, so the character must wait in the buffer
        stop_in <= 1'b1;
        tx_write_in <= 1'b1;
        @(posedge clk_in);
        tx_write_in <= 1'b0;
        repeat (40) @(posedge clk_in);
        `ASI_CHECK("stop freeze", 1'b0, tx_empty_out)
        stop_in <= 1'b0;
        wait_hi(1);
        tx_en_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        `ASI_CHECK("txd released", 1'b0, txd_oe_out)
        end_of_test();
    end
endmodule // asi_tb_top
